// *** logic/rcr_readout.sv ***
// Rotary cursor readout: sampling, encoding, timeout blink, derating and APB registers.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module rcr_readout
	import rcr_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [3:0]  defl_x,
	input  wire logic signed [3:0]  defl_y,
	input  wire logic [4:0]         notch_pos,
	input  wire logic               notch_valid,
	input  wire logic               notch_fault,
	input  wire logic               push_in,
	input  wire logic               push_valid,
	input  wire logic               push_fault,
	input  wire logic signed [15:0] temp_base,
	input  wire logic signed [15:0] temp_handle,
	input  wire logic               sample_strobe,
	input  wire logic [47:0]        unique_id,
	input  wire logic               prop_a_rx,
	input  wire logic               bus_msg_rx,
	output logic [7:0]              halo_red,
	output logic [7:0]              halo_green,
	output logic [7:0]              halo_blue,
	output logic                    blink_active,
	output logic                    irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	logic [40:0] raw_in;
	logic [40:0] syn_in;
	assign raw_in = {defl_x, defl_y, notch_pos, notch_valid, notch_fault, push_in, push_valid, push_fault,
		temp_base, sample_strobe, prop_a_rx, bus_msg_rx, 4'h0};

	// Sensor, base temperature, strobe and message pins pass the shared three-stage agreement filter.
	rcr_sync #(.W(41)) u_sync (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (raw_in),
		.sync_out (syn_in)
	);

	logic [15:0] handle_syn;
	logic [47:0] uid_syn;

	// Handle temperature and identifier pins take their own filters of the same kind.
	rcr_sync #(.W(16)) u_sync_handle (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (temp_handle),
		.sync_out (handle_syn)
	);
	rcr_sync #(.W(48)) u_sync_uid (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (unique_id),
		.sync_out (uid_syn)
	);

	wire logic signed [3:0]  sx       = syn_in[40:37];
	wire logic signed [3:0]  sy       = syn_in[36:33];
	wire logic [4:0]         s_notch  = syn_in[32:28];
	wire logic               s_nvalid = syn_in[27];
	wire logic               s_nfault = syn_in[26];
	wire logic               s_push   = syn_in[25];
	wire logic               s_pvalid = syn_in[24];
	wire logic               s_pfault = syn_in[23];
	wire logic signed [15:0] s_tbase  = syn_in[22:7];
	wire logic               s_strobe = syn_in[6];
	wire logic               s_prop_a = syn_in[5];
	wire logic               s_busmsg = syn_in[4];

	////////////////////////////////////////////////////////////////////////////////
	// Encoding of the sampled values.

	logic canopen_reg;
	logic strobe_d_reg;
	wire logic sample_evt = s_strobe & ~strobe_d_reg;

	// signed clamp; keeps every step between the limits.
	function automatic logic [7:0] clamp_axis(input logic signed [3:0] v);
		logic signed [7:0] w;
		w = 8'(signed'(v));
		if (w > RCR_DEFL_MAX) begin
			w = RCR_DEFL_MAX;
		end else if (w < RCR_DEFL_MIN) begin
			w = RCR_DEFL_MIN;
		end
		return w;
	endfunction

	wire logic [7:0] cx = clamp_axis(sx);
	wire logic [7:0] cy = clamp_axis(sy);
	// bias by 125; bias maps the clamp onto 118..132.
	wire logic [7:0] jx = 8'(cx + RCR_J1939_BIAS);
	wire logic [7:0] jy = 8'(cy + RCR_J1939_BIAS);
	wire logic [7:0] dir_x_enc = canopen_reg ? cx : jx;
	wire logic [7:0] dir_y_enc = canopen_reg ? cy : jy;

	// notch codes; out-of-range positions report error, never reserved.
	wire logic notch_in_range = ({3'h0, s_notch} >= RCR_NOTCH_FIRST) && ({3'h0, s_notch} <= RCR_NOTCH_LAST);
	wire logic [7:0] notch_enc = s_nfault ? RCR_CODE_ERROR :
		!s_nvalid ? RCR_CODE_NA :
		notch_in_range ? {3'h0, s_notch} : RCR_CODE_ERROR;

	wire logic [7:0] push_enc = s_pfault ? RCR_CODE_ERROR :
		!s_pvalid ? RCR_CODE_NA :
		s_push ? RCR_PUSH_ON : RCR_PUSH_OFF;

	// J1939 temperatures take the low byte, CANopen the whole signed word.
	wire logic [15:0] tb_enc = canopen_reg ? s_tbase : {8'h00, s_tbase[7:0]};
	wire logic [15:0] th_enc = canopen_reg ? handle_syn : {8'h00, handle_syn[7:0]};

	logic [7:0]  dir_x_reg;
	logic [7:0]  dir_y_reg;
	logic [7:0]  notch_reg;
	logic [7:0]  push_reg;
	logic [15:0] tbase_reg;
	logic [15:0] thandle_reg;
	logic [47:0] uid_reg;

	// every published object is loaded together on one sample edge.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			strobe_d_reg <= 1'b0;
			dir_x_reg    <= RCR_J1939_BIAS;
			dir_y_reg    <= RCR_J1939_BIAS;
			notch_reg    <= RCR_CODE_NA;
			push_reg     <= RCR_CODE_NA;
			tbase_reg    <= 16'h0000;
			thandle_reg  <= 16'h0000;
			uid_reg      <= 48'h000000000000;
		end else begin
			strobe_d_reg <= s_strobe;
			if (sample_evt) begin
				dir_x_reg   <= dir_x_enc;
				dir_y_reg   <= dir_y_enc;
				// position is the absolute sensor value, restored on the first sample.
				notch_reg   <= notch_enc;
				push_reg    <= push_enc;
				tbase_reg   <= tb_enc;
				thandle_reg <= th_enc;
				uid_reg     <= uid_syn;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Communication timeout and blink.

	logic [15:0] timeout_ms_reg;
	logic [15:0] ms_cnt_reg;
	logic [15:0] ms_elapsed_reg;
	logic        timeout_reg;
	logic [23:0] blink_cnt_reg;
	logic        blink_phase_reg;
	logic        sw_msg_pulse;
	wire logic   msg_seen = s_prop_a | s_busmsg | sw_msg_pulse;
	wire logic   ms_tick  = (ms_cnt_reg == RCR_MS_CYCLES - 16'h0001);
	// two seconds without messages in J1939 mode only; period taken from its register.
	wire logic   timeout_hit = !canopen_reg && ms_tick && (ms_elapsed_reg + 16'h0001 >= timeout_ms_reg);

	// Millisecond timer restarts on every received message.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ms_cnt_reg     <= 16'h0000;
			ms_elapsed_reg <= 16'h0000;
			timeout_reg    <= 1'b0;
		end else if (msg_seen) begin
			ms_cnt_reg     <= 16'h0000;
			ms_elapsed_reg <= 16'h0000;
			timeout_reg    <= 1'b0;
		end else begin
			ms_cnt_reg <= ms_tick ? 16'h0000 : 16'(ms_cnt_reg + 16'h0001);
			if (ms_tick && !timeout_reg) begin
				ms_elapsed_reg <= 16'(ms_elapsed_reg + 16'h0001);
			end
			if (timeout_hit) begin
				timeout_reg <= 1'b1;
			end
		end
	end

	// Blink phase toggles while timed out.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			blink_cnt_reg   <= 24'h000000;
			blink_phase_reg <= 1'b0;
		end else if (!timeout_reg) begin
			blink_cnt_reg   <= 24'h000000;
			blink_phase_reg <= 1'b0;
		end else if (blink_cnt_reg == 24'(RCR_BLINK_CYCLES - 1)) begin
			blink_cnt_reg   <= 24'h000000;
			blink_phase_reg <= ~blink_phase_reg;
		end else begin
			blink_cnt_reg <= 24'(blink_cnt_reg + 24'h000001);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Halo lighting with derating.

	logic [7:0]  light_r_reg;
	logic [7:0]  light_g_reg;
	logic [7:0]  light_b_reg;
	logic [2:0]  light_idx_reg;
	logic [2:0]  pattern_reg;
	// hot when either temperature byte passes the limit.
	wire logic hot = (tbase_reg[7:0] > RCR_HOT_LIMIT_C) || (thandle_reg[7:0] > RCR_HOT_LIMIT_C);
	// only index 7 addresses this halo.
	wire logic idx_ok = (light_idx_reg == RCR_LIGHT_INDEX);
	wire logic [7:0] dr = hot ? (light_r_reg >> RCR_DERATE_SHIFT) : light_r_reg;
	wire logic [7:0] dg = hot ? (light_g_reg >> RCR_DERATE_SHIFT) : light_g_reg;
	wire logic [7:0] db = hot ? (light_b_reg >> RCR_DERATE_SHIFT) : light_b_reg;
	wire logic [7:0] white = blink_phase_reg ? RCR_CODE_NA : 8'h00;

	// timeout shows white flashes on the halo.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			halo_red     <= 8'h00;
			halo_green   <= 8'h00;
			halo_blue    <= 8'h00;
			blink_active <= 1'b0;
		end else begin
			halo_red     <= timeout_reg ? white : (idx_ok ? dr : 8'h00);
			halo_green   <= timeout_reg ? white : (idx_ok ? dg : 8'h00);
			halo_blue    <= timeout_reg ? white : (idx_ok ? db : 8'h00);
			blink_active <= timeout_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, interrupts and control registers.

	logic [RCR_INT_WIDTH-1:0] int_stat_reg;
	logic [RCR_INT_WIDTH-1:0] int_mask_reg;
	logic                     timeout_d_reg;
	logic                     hot_d_reg;
	logic [7:0]               uid_sel_reg;
	wire logic wr = psel & penable & pwrite;
	wire logic [RCR_INT_WIDTH-1:0] int_evt = {sample_evt, hot & ~hot_d_reg, timeout_reg & ~timeout_d_reg};
	wire logic uid_sel_ok = (uid_sel_reg <= RCR_UID_LAST_SUB);
	wire logic [7:0] uid_byte = uid_sel_ok ? uid_reg[8*uid_sel_reg[2:0] +: 8] : 8'h00;
	// rotate pattern is refused and reads back as continuous.
	wire logic [2:0] pattern_next = (pwdata[26:24] >= RCR_PATTERN_ROTATE) ? 3'h0 : pwdata[26:24];
	assign sw_msg_pulse = wr && (paddr == RCR_CTRL_OFS) && pwdata[RCR_CTRL_MSG_BIT];
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign irq     = |(int_stat_reg & int_mask_reg);

	// Software writes; events win over a write-one clear.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			canopen_reg    <= 1'b0;
			int_stat_reg   <= '0;
			int_mask_reg   <= '0;
			timeout_d_reg  <= 1'b0;
			hot_d_reg      <= 1'b0;
			timeout_ms_reg <= RCR_TIMEOUT_MS_RESET;
			uid_sel_reg    <= 8'h00;
			light_r_reg    <= 8'h00;
			light_g_reg    <= 8'h00;
			light_b_reg    <= 8'h00;
			light_idx_reg  <= RCR_LIGHT_INDEX;
			pattern_reg    <= 3'h0;
		end else begin
			timeout_d_reg <= timeout_reg;
			hot_d_reg     <= hot;
			int_stat_reg  <= (int_stat_reg & ~((wr && paddr == RCR_INT_STAT_OFS) ?
				pwdata[RCR_INT_WIDTH-1:0] : '0)) | int_evt;
			if (wr && paddr == RCR_CTRL_OFS) canopen_reg <= pwdata[RCR_CTRL_CANOPEN_BIT];
			if (wr && paddr == RCR_INT_MASK_OFS) int_mask_reg <= pwdata[RCR_INT_WIDTH-1:0];
			if (wr && paddr == RCR_TIMEOUT_OFS) timeout_ms_reg <= pwdata[15:0];
			if (wr && paddr == RCR_UID_BYTE_OFS) uid_sel_reg <= pwdata[7:0];
			// entering timeout returns LED settings to off.
			if (timeout_reg && !timeout_d_reg) begin
				light_r_reg <= 8'h00;
				light_g_reg <= 8'h00;
				light_b_reg <= 8'h00;
			end else if (wr && paddr == RCR_LIGHT_OFS) begin
				light_r_reg   <= pwdata[7:0];
				light_g_reg   <= pwdata[15:8];
				light_b_reg   <= pwdata[23:16];
				pattern_reg   <= pattern_next;
				light_idx_reg <= pwdata[30:28];
			end
		end
	end

	// ID as a low 32-bit and a high 16-bit word, or bytes 0 to 5 by selector.
	always_comb begin
		unique case (paddr)
			RCR_CTRL_OFS:     prdata = {31'h0, canopen_reg};
			RCR_STATUS_OFS:   prdata = {29'h0, hot, blink_phase_reg, timeout_reg};
			RCR_INT_STAT_OFS: prdata = {29'h0, int_stat_reg};
			RCR_INT_MASK_OFS: prdata = {29'h0, int_mask_reg};
			RCR_DIR_OFS:      prdata = {16'h0, dir_y_reg, dir_x_reg};
			RCR_NOTCH_OFS:    prdata = {16'h0, push_reg, notch_reg};
			RCR_TEMP_OFS:     prdata = {thandle_reg, tbase_reg};
			RCR_UID_LO_OFS:   prdata = uid_reg[31:0];
			RCR_UID_HI_OFS:   prdata = {16'h0, uid_reg[47:32]};
			RCR_VERSION_OFS:  prdata = {16'h0, RCR_SW_VERSION, RCR_HW_VERSION};
			RCR_TIMEOUT_OFS:  prdata = {16'h0, timeout_ms_reg};
			RCR_UID_BYTE_OFS: prdata = {16'h0, uid_byte, uid_sel_reg};
			RCR_LIGHT_OFS:    prdata = {1'b0, light_idx_reg, 1'b0, pattern_reg, light_b_reg, light_g_reg, light_r_reg};
			default:          prdata = 32'h00000000;
		endcase
	end
endmodule

// *** logic/rcr_pkg.sv ***
// Package of constants for the rotary cursor readout block.
package rcr_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] RCR_CTRL_OFS      = 8'h00;
	localparam logic [7:0] RCR_STATUS_OFS    = 8'h04;
	localparam logic [7:0] RCR_INT_STAT_OFS  = 8'h08;
	localparam logic [7:0] RCR_INT_MASK_OFS  = 8'h0C;
	localparam logic [7:0] RCR_DIR_OFS       = 8'h10;
	localparam logic [7:0] RCR_NOTCH_OFS     = 8'h14;
	localparam logic [7:0] RCR_TEMP_OFS      = 8'h18;
	localparam logic [7:0] RCR_UID_LO_OFS    = 8'h1C;
	localparam logic [7:0] RCR_UID_HI_OFS    = 8'h20;
	localparam logic [7:0] RCR_VERSION_OFS   = 8'h24;
	localparam logic [7:0] RCR_TIMEOUT_OFS   = 8'h28;
	localparam logic [7:0] RCR_UID_BYTE_OFS  = 8'h2C;
	localparam logic [7:0] RCR_LIGHT_OFS     = 8'h30;
	// Control register fields.
	localparam int RCR_CTRL_CANOPEN_BIT = 0;
	localparam int RCR_CTRL_MSG_BIT     = 1;
	// Interrupt status fields.
	localparam int RCR_INT_TIMEOUT_BIT = 0;
	localparam int RCR_INT_HOT_BIT     = 1;
	localparam int RCR_INT_SAMPLE_BIT  = 2;
	localparam int RCR_INT_WIDTH       = 3;
	// Encodings.
	localparam logic [7:0] RCR_J1939_BIAS    = 8'h7D;
	localparam logic [7:0] RCR_J1939_MAX     = 8'h84;
	localparam logic [7:0] RCR_J1939_MIN     = 8'h76;
	localparam logic signed [7:0] RCR_DEFL_MAX = 8'sh07;
	localparam logic signed [7:0] RCR_DEFL_MIN = -8'sh07;
	localparam logic [7:0] RCR_NOTCH_FIRST   = 8'h01;
	localparam logic [7:0] RCR_NOTCH_LAST    = 8'h14;
	localparam logic [7:0] RCR_CODE_ERROR    = 8'hFE;
	localparam logic [7:0] RCR_CODE_NA       = 8'hFF;
	localparam logic [7:0] RCR_PUSH_OFF      = 8'h00;
	localparam logic [7:0] RCR_PUSH_ON       = 8'h01;
	localparam logic [7:0] RCR_UID_LAST_SUB  = 8'h05;
	localparam logic [2:0] RCR_LIGHT_INDEX   = 3'h7;
	localparam logic [2:0] RCR_PATTERN_ROTATE = 3'h4;
	localparam logic [7:0] RCR_HOT_LIMIT_C   = 8'h55;
	localparam logic [7:0] RCR_DERATE_SHIFT  = 8'h01;
	// Timing.
	localparam int RCR_CLK_HZ         = 10000000;
	localparam int RCR_TIMEOUT_MS     = 2000;
	localparam int RCR_TIMEOUT_CYCLES = RCR_CLK_HZ / 1000 * RCR_TIMEOUT_MS;
	localparam int RCR_BLINK_MS       = 250;
	localparam int RCR_BLINK_CYCLES   = RCR_CLK_HZ / 1000 * RCR_BLINK_MS;
	localparam logic [15:0] RCR_TIMEOUT_MS_RESET = 16'h07D0;
	localparam logic [15:0] RCR_MS_CYCLES = 16'h2710;
	// Version values; arbitrary.
	localparam logic [7:0] RCR_HW_VERSION = 8'h01;
	localparam logic [7:0] RCR_SW_VERSION = 8'h01;
endpackage

// *** logic/rcr_sync.sv ***
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module rcr_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// The first stage feeds only the second; output moves when stages two and three agree.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			sync_out <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				sync_out <= s3_reg;
			end
		end
	end
endmodule

// *** verification/rcr_readout_sva.sv ***
// Checker of the readout block's port behaviour.
`timescale 1ns/1ps
module rcr_readout_chk
	import rcr_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        prop_a_rx,
	input wire logic [7:0]  halo_red,
	input wire logic [7:0]  halo_green,
	input wire logic [7:0]  halo_blue,
	input wire logic        blink_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Marks the access phase of a read.
	wire rd_acc = psel && penable && !pwrite;
	////////////////////////////////////////
	a_ready_zero_wait: assert property (psel && !penable |=> pready)
		else $error("pready low in access phase");
	a_no_slave_err: assert property (psel && penable |-> !pslverr)
		else $error("pslverr raised");
	a_dir_range: assert property (rd_acc && paddr == RCR_DIR_OFS |->
		prdata[7:0] inside {[8'h76:8'h84], [8'hF9:8'hFF], [8'h00:8'h07]} &&
		prdata[15:8] inside {[8'h76:8'h84], [8'hF9:8'hFF], [8'h00:8'h07]})
		else $error("deflection outside range");
	a_notch_codes: assert property (rd_acc && paddr == RCR_NOTCH_OFS |->
		prdata[7:0] inside {[8'h01:8'h14], 8'hFE, 8'hFF}) else $error("reserved notch code");
	a_push_codes: assert property (rd_acc && paddr == RCR_NOTCH_OFS |->
		prdata[15:8] inside {8'h00, 8'h01, 8'hFE, 8'hFF}) else $error("reserved push code");
	a_no_rotate: assert property (rd_acc && paddr == RCR_LIGHT_OFS |-> !prdata[26])
		else $error("rotate pattern offered");
	a_halo_white: assert property (blink_active && $past(blink_active) |->
		halo_red == halo_green && halo_green == halo_blue) else $error("halo not white");
	a_resume_msg: assert property (prop_a_rx [*4] |-> ##[0:12] !blink_active)
		else $error("timeout kept after message");
endmodule
bind rcr_readout rcr_readout_chk u_chk (
	.sys_clk      (sys_clk),
	.nrst         (nrst),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.prdata       (prdata),
	.pready       (pready),
	.pslverr      (pslverr),
	.prop_a_rx    (prop_a_rx),
	.halo_red     (halo_red),
	.halo_green   (halo_green),
	.halo_blue    (halo_blue),
	.blink_active (blink_active)
);

// *** verification/rcr_host_model.sv ***
// Far-side model: host messages and sensor sampling pulses.
`timescale 1ns/1ps
module rcr_host_model (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic go_sample,
	input  wire logic go_msg,
	output logic      sample_strobe,
	output logic      prop_a_rx,
	output logic      bus_msg_rx
);
	logic [2:0] smp_cnt_reg;
	logic [2:0] msg_cnt_reg;
	// Stretches each request to four cycles so the input filter accepts it.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			smp_cnt_reg <= 3'h0;
			msg_cnt_reg <= 3'h0;
		end else begin
			smp_cnt_reg <= go_sample ? 3'h4 : smp_cnt_reg - {2'h0, |smp_cnt_reg};
			msg_cnt_reg <= go_msg ? 3'h4 : msg_cnt_reg - {2'h0, |msg_cnt_reg};
		end
	end
	assign sample_strobe = |smp_cnt_reg;
	assign prop_a_rx  = |msg_cnt_reg;
	assign bus_msg_rx = |msg_cnt_reg;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench of the rotary cursor readout block.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb_top
	import rcr_pkg::*;
	;
	logic               sys_clk = 1'b0;
	logic               nrst, psel, penable, pwrite, go_sample, go_msg, i0;
	logic [7:0]         paddr, halo_red, halo_green, halo_blue;
	logic [31:0]        pwdata, prdata, e, exp_q[$], msk_q[$];
	logic signed [3:0]  defl_x, defl_y;
	logic [4:0]         notch_pos;
	logic               notch_valid, notch_fault, push_in, push_valid, push_fault;
	logic               sample_strobe, prop_a_rx, bus_msg_rx, pready, pslverr, blink_active, irq;
	logic signed [15:0] temp_base, temp_handle;
	logic [47:0]        unique_id;
	int                 mismatches = 0;
	int                 comparisons = 0;
	// Flags: notch valid, notch fault, pressed, push valid, push fault.
	logic [9:0]  ncfg[6] = '{{5'h00, 5'h12}, {5'h01, 5'h16}, {5'h14, 5'h13},
	                         {5'h15, 5'h10}, {5'h05, 5'h02}, {5'h05, 5'h1E}};
	logic [15:0] nexp[6] = '{16'h00FE, 16'h0101, 16'hFE14, 16'hFFFE, 16'h00FF, 16'h01FE};
	rcr_host_model u_host (.sys_clk(sys_clk), .nrst(nrst), .go_sample(go_sample), .go_msg(go_msg),
		.sample_strobe(sample_strobe), .prop_a_rx(prop_a_rx), .bus_msg_rx(bus_msg_rx));
	rcr_readout u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.defl_x(defl_x), .defl_y(defl_y), .notch_pos(notch_pos), .notch_valid(notch_valid),
		.notch_fault(notch_fault), .push_in(push_in), .push_valid(push_valid), .push_fault(push_fault),
		.temp_base(temp_base), .temp_handle(temp_handle), .sample_strobe(sample_strobe),
		.unique_id(unique_id), .prop_a_rx(prop_a_rx), .bus_msg_rx(bus_msg_rx), .halo_red(halo_red),
		.halo_green(halo_green), .halo_blue(halo_blue), .blink_active(blink_active), .irq(irq));
	// Clock of 100 ns period.
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_q.push_back(x);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pulse_smp();
		go_sample <= 1'b1;
		@(posedge sys_clk);
		go_sample <= 1'b0;
		repeat (20) @(posedge sys_clk);
	endtask
	task automatic smp();
		pulse_smp();
		rd(RCR_INT_STAT_OFS, 32'h4, 32'h4);
		apb(1'b1, RCR_INT_STAT_OFS, 32'h4);
	endtask
	task automatic rst_vals();
		rd(RCR_DIR_OFS, 32'hFFFF, 32'h7D7D);
		rd(RCR_NOTCH_OFS, 32'hFFFF, 32'hFFFF);
		rd(RCR_TIMEOUT_OFS, 32'hFFFF, 32'h07D0);
		rd(RCR_LIGHT_OFS, 32'h7000_0000, 32'h7000_0000);
		rd(8'h34, 32'hFFFF_FFFF, 32'h0);
	endtask
	// Compares each completed read with the oldest note.
	always @(posedge sys_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
			`CHK(prdata & msk_q[0], exp_q[0])
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// Cuts a hung run short.
	initial begin
		repeat (70000) @(posedge sys_clk);
		mismatches++;
		final_report();
	end
	// Main sequence of scenarios.
	initial begin
		int c, cy, n;
		logic [47:0] uid;
		logic [15:0] t0, t1;
		void'($urandom(62907));
		{nrst, psel, penable, pwrite, go_sample, go_msg, paddr, pwdata} <= '0;
		{defl_x, defl_y, notch_pos, notch_valid, notch_fault, push_in, push_valid, push_fault} <= '0;
		{temp_base, temp_handle, unique_id} <= '0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rst_vals();
		apb(1'b1, RCR_INT_MASK_OFS, 32'h0);
		pulse_smp();
		i0 = irq;
		apb(1'b1, RCR_INT_MASK_OFS, 32'h4);
		@(negedge sys_clk);
		`CHK(irq ^ i0, 1'b1)
		@(posedge sys_clk);
		apb(1'b1, RCR_INT_STAT_OFS, 32'h4);
		@(negedge sys_clk);
		`CHK(irq, 1'b0)
		@(posedge sys_clk);
		for (int d = -8; d < 8; d++) begin
			c = (d < -7) ? -7 : d;
			cy = (d == -8) ? -7 : -d;
			defl_x <= 4'(d);
			defl_y <= 4'(-d);
			for (int m = 0; m < 2; m++) begin
				apb(1'b1, RCR_CTRL_OFS, 32'(m));
				smp();
				e = m ? {16'h0, 8'(cy), 8'(c)} : {16'h0, 8'(125 + cy), 8'(125 + c)};
				rd(RCR_DIR_OFS, 32'hFFFF, e);
			end
		end
		for (int k = 0; k < 6; k++) begin
			{notch_pos, notch_valid, notch_fault, push_in, push_valid, push_fault} <= ncfg[k];
			smp();
			rd(RCR_NOTCH_OFS, 32'hFFFF, {16'h0, nexp[k]});
		end
		{notch_pos, notch_valid, notch_fault} <= {5'h09, 2'h2};
		smp();
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rst_vals();
		smp();
		rd(RCR_NOTCH_OFS, 32'hFF, 32'h09);
		t0 = 16'($urandom);
		t1 = 16'($urandom);
		uid = {16'($urandom), $urandom};
		{temp_base, temp_handle, unique_id} <= {t0, t1, uid};
		smp();
		rd(RCR_TEMP_OFS, 32'hFFFF_FFFF, {8'h00, t1[7:0], 8'h00, t0[7:0]});
		apb(1'b1, RCR_CTRL_OFS, 32'h1);
		smp();
		rd(RCR_TEMP_OFS, 32'hFFFF_FFFF, {t1, t0});
		rd(RCR_UID_LO_OFS, 32'hFFFF_FFFF, uid[31:0]);
		rd(RCR_UID_HI_OFS, 32'hFFFF, {16'h0, uid[47:32]});
		for (int s = 0; s < 7; s++) begin
			apb(1'b1, RCR_UID_BYTE_OFS, 32'(s));
			rd(RCR_UID_BYTE_OFS, 32'hFF00, (s < 6) ? {16'h0, uid[8*s +: 8], 8'h0} : 32'h0);
		end
		foreach (nexp[j]) begin
			{temp_base, temp_handle} <= {2{16'h0019 + 16'(j % 3 == 1) * 16'h003D - 16'(j % 3 == 2)}};
			if (j == 0) apb(1'b1, RCR_LIGHT_OFS, 32'h7420_4080);
			if (j == 0) rd(RCR_LIGHT_OFS, 32'h7700_0000, 32'h7000_0000);
			smp();
			rd(RCR_STATUS_OFS, 32'h4, (j % 3 == 1) ? 32'h4 : 32'h0);
			@(negedge sys_clk);
			`CHK({halo_red, halo_green, halo_blue}, (j % 3 == 1) ? 24'h402010 : 24'h804020)
			@(posedge sys_clk);
		end
		apb(1'b1, RCR_LIGHT_OFS, 32'h6020_4080);
		@(negedge sys_clk);
		`CHK({halo_red, halo_green, halo_blue}, 24'h0)
		@(posedge sys_clk);
		apb(1'b1, RCR_CTRL_OFS, 32'h2);
		apb(1'b1, RCR_TIMEOUT_OFS, 32'h2);
		repeat (2 * RCR_MS_CYCLES - 20) @(posedge sys_clk); // Just short of two milliseconds.
		`CHK(blink_active, 1'b0)
		for (n = 0; blink_active !== 1'b1 && n < 40; n++) @(posedge sys_clk);
		`CHK(blink_active, 1'b1)
		rd(RCR_STATUS_OFS, 32'h1, 32'h1);
		rd(RCR_LIGHT_OFS, 32'hFF_FFFF, 32'h0);
		rd(RCR_INT_STAT_OFS, 32'h1, 32'h1);
		go_msg <= 1'b1;
		@(posedge sys_clk);
		go_msg <= 1'b0;
		for (n = 0; blink_active !== 1'b0 && n < 50; n++) @(posedge sys_clk);
		`CHK(blink_active, 1'b0)
		final_report();
	end
endmodule
